// *** src/obd_select_map.svh ***
// offsets, field positions, reset values and timing counts for protocol selection
`ifndef OBD_SELECT_MAP_SVH
`define OBD_SELECT_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_COMMAND 8'h00
`define OFS_STATUS 8'h04
`define OFS_CONFIG 8'h08
`define OFS_DESCRIBE 8'h0c

// ----------------------------------------
// command register fields
// ----------------------------------------
`define CMD_CODE_LSB 0
`define CMD_AUTO_BIT 4
`define CMD_OP_LSB 8

// ----------------------------------------
// status register fields
// ----------------------------------------
`define ST_CURRENT_LSB 0
`define ST_DEFAULT_LSB 4
`define ST_DEFAULT_AUTO_BIT 8
`define ST_BUSY_BIT 9
`define ST_CONNECTED_BIT 10
`define ST_NO_CONNECT_BIT 11
`define ST_CHECKSUM_ERR_BIT 12
`define ST_LENGTH_ERR_BIT 13

// ----------------------------------------
// config register fields
// ----------------------------------------
`define CFG_HEADER_BIT 0
`define CFG_MEMORY_BIT 1
`define CFG_BAUD_FAST_BIT 2

// ----------------------------------------
// describe register fields
// ----------------------------------------
`define DSC_CODE_LSB 0
`define DSC_AUTO_BIT 4
`define DSC_CAN_BIT 5
`define DSC_ID29_BIT 6
`define DSC_RATE_LSB 8

// ----------------------------------------
// protocol codes and frame limits
// ----------------------------------------
`define PROTO_AUTO 4'h0
`define PROTO_FIRST 4'h1
`define PROTO_LAST 4'h9
`define PROTO_CAN_FIRST 4'h6
`define RESET_DEFAULT_CODE 4'h0
`define RESET_DEFAULT_AUTO 1'b1
`define HEADER_BYTES 4'h3
`define MAX_DATA_BYTES 4'h7
`define CAN_ID11_BYTES 4'h2
`define CAN_ID29_BYTES 4'h4

// ----------------------------------------
// host serial rates and divisors at the bus clock
// ----------------------------------------
`define CLOCK_HZ 25000000
`define BAUD_SLOW 9600
`define BAUD_FAST 38400
`define BAUD_DIV_SLOW (`CLOCK_HZ / `BAUD_SLOW)
`define BAUD_DIV_FAST (`CLOCK_HZ / `BAUD_FAST)

// ----------------------------------------
// vehicle bus rates in hundreds of baud
// ----------------------------------------
`define RATE_PWM 16'd416
`define RATE_VPW 16'd104
`define RATE_CAN500 16'd5000
`define RATE_CAN250 16'd2500
`define RATE_SLOW_INIT 16'd104

`endif

// *** src/obd_select_pkg.sv ***
// types shared by the protocol selection and framing block
package obd_select_pkg;

   typedef enum logic [2:0] {
      op_none = 3'b000,
      op_set_protocol = 3'b001,
      op_try_protocol = 3'b010,
      op_restore_defaults = 3'b011,
      op_connect = 3'b100,
      op_close = 3'b101
   } op_t;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_start = 3'b001,
      st_wait = 3'b010,
      st_next = 3'b011,
      st_connected = 3'b100
   } search_state_t;

   typedef enum logic [1:0] {
      kind_header = 2'b00,
      kind_pci = 2'b01,
      kind_data = 2'b10,
      kind_checksum = 2'b11
   } byte_kind_t;

endpackage

// *** src/obd_protocol_select.sv ***
// protocol selection, search and message framing behind an ahb-lite register port
`timescale 1ns/1ns
`default_nettype none
`include "obd_select_map.svh"

// Notes on behaviour
// [RL1] host link 9600 or 38400, 8N1
// [RL2] codes 0 auto, 1-5 non-CAN protocols
// [RL3] codes 6-9 CAN, 11/29 bit, 500/250k
// [RL4] set-protocol stores code as default
// [RL5] describe shows current protocol plus auto marker
// [RL6] A-prefix: try given code, then search
// [RL7] fixed code failure never starts search
// [RL8] memory on: found protocol becomes default
// [RL9] try A-prefix: guess first, then ascend from 1
// [RL10] auto with memory: found protocol tried first
// [RL11] reset default is automatic search
// [RL12] non-CAN: 3 header, <=7 data, 1 checksum
// [RL13] header order priority, target, source
// [RL14] checksum last; mismatch flags an error
// [RL15] CAN: ID bits, PCI, up to 7 data; code flags length_err only at 9 or more data bytes
// [RL16] header display off hides header and checksum
// [RL17] CAN headers: ID bytes then PCI byte
// [RL18] never forward CAN checksum or IN_FRAME_RESPONSE_BYTES bytes
// [RL19] restore: differing protocol closes session, switches
// [RL20] search exhausted reports no connection
module obd_protocol_select #(
   parameter int unsigned DIV_WIDTH = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic memory_strap,
   input wire logic baud_strap,
   output logic [DIV_WIDTH-1:0] host_baud_div,
   output logic [3:0] link_protocol,
   output logic link_start,
   output logic link_close,
   input wire logic link_done,
   input wire logic link_ok,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_ifr,
   output logic host_valid,
   output logic [7:0] host_data,
   output obd_select_pkg::byte_kind_t host_kind,
   output logic host_frame_end
);
   import obd_select_pkg::*;

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic wr_pending;
   logic [7:0] wr_addr;
   logic addr_valid;

   assign addr_valid = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pending <= addr_valid && hwrite;
         if (addr_valid) begin
            wr_addr <= haddr;
         end
      end
   end

   // zero wait states, errors never raised
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic cmd_write;
   logic cfg_write;
   logic st_write;
   op_t cmd_op;
   logic [3:0] cmd_code;
   logic cmd_auto;

   assign cmd_write = wr_pending && (wr_addr == `OFS_COMMAND);
   assign cfg_write = wr_pending && (wr_addr == `OFS_CONFIG);
   assign st_write = wr_pending && (wr_addr == `OFS_STATUS);
   assign cmd_op = op_t'(hwdata[`CMD_OP_LSB +: 3]);
   assign cmd_code = hwdata[`CMD_CODE_LSB +: 4];
   assign cmd_auto = hwdata[`CMD_AUTO_BIT];

   // ----------------------------------------
   // configuration
   // ----------------------------------------
   logic header_on;
   logic memory_on;
   logic baud_fast;
   logic strap_taken;

   // straps caught at the first clock after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         header_on <= 1'b0;
         memory_on <= 1'b0;
         baud_fast <= 1'b0;
         strap_taken <= 1'b0;
      end else begin
         strap_taken <= 1'b1;
         if (!strap_taken) begin
            memory_on <= memory_strap;
            baud_fast <= baud_strap;
         end else if (cfg_write) begin
            // [RL16] header display switch
            header_on <= hwdata[`CFG_HEADER_BIT];
            memory_on <= hwdata[`CFG_MEMORY_BIT];
            baud_fast <= hwdata[`CFG_BAUD_FAST_BIT];
         end
      end
   end

   // [RL1] host rate divisor
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_baud_div <= DIV_WIDTH'(`BAUD_DIV_SLOW);
      end else begin
         host_baud_div <= baud_fast ? DIV_WIDTH'(`BAUD_DIV_FAST) : DIV_WIDTH'(`BAUD_DIV_SLOW);
      end
   end

   // ----------------------------------------
   // protocol selection and search
   // ----------------------------------------
   logic [3:0] default_code;
   logic default_auto;
   logic [3:0] sel_code;
   logic sel_auto;
   logic [3:0] current_code;
   logic [3:0] first_code;
   logic from_search;
   logic try_auto;
   logic no_connect;
   search_state_t state;
   logic code_valid;
   logic found_by_search;

   assign code_valid = (cmd_code <= `PROTO_LAST);
   assign found_by_search = (state == st_wait) && link_done && link_ok && from_search;

   // [RL11] factory default is automatic
   // [RL4] set-protocol becomes the default
   // [RL8] found protocol written back with memory on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         default_code <= `RESET_DEFAULT_CODE;
         default_auto <= `RESET_DEFAULT_AUTO;
      end else if (cmd_write && cmd_op == op_set_protocol && code_valid) begin
         default_code <= cmd_code;
         default_auto <= cmd_auto || (cmd_code == `PROTO_AUTO);
      end else if (found_by_search && memory_on) begin
         // [RL10] auto stays on, found code tried first
         default_code <= current_code;
         default_auto <= 1'b1;
      end
   end

   // active selection, taken from commands or from the default
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_code <= `RESET_DEFAULT_CODE;
         sel_auto <= `RESET_DEFAULT_AUTO;
      end else if (cmd_write && code_valid &&
                   (cmd_op == op_set_protocol || cmd_op == op_try_protocol)) begin
         // [RL6] A-prefix keeps fallback search allowed
         sel_code <= cmd_code;
         sel_auto <= cmd_auto || (cmd_code == `PROTO_AUTO);
      end else if (cmd_write && cmd_op == op_restore_defaults) begin
         sel_code <= default_code;
         sel_auto <= default_auto;
      end else if (found_by_search && memory_on) begin
         sel_code <= current_code;
         sel_auto <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= st_idle;
         current_code <= `RESET_DEFAULT_CODE;
         first_code <= `RESET_DEFAULT_CODE;
         from_search <= 1'b0;
         try_auto <= 1'b0;
         link_start <= 1'b0;
         link_close <= 1'b0;
         link_protocol <= `RESET_DEFAULT_CODE;
      end else begin
         link_start <= 1'b0;
         link_close <= 1'b0;
         case (state)
            st_idle: begin
               try_auto <= cmd_auto && cmd_op == op_try_protocol;
               if (cmd_write && code_valid && cmd_op == op_try_protocol) begin
                  // [RL9] the guess goes first
                  first_code <= cmd_code;
                  current_code <= (cmd_code == `PROTO_AUTO) ? `PROTO_FIRST : cmd_code;
                  from_search <= (cmd_code == `PROTO_AUTO);
                  state <= st_start;
               end else if (cmd_write && cmd_op == op_connect) begin
                  first_code <= sel_code;
                  current_code <= (sel_code == `PROTO_AUTO) ? `PROTO_FIRST : sel_code;
                  from_search <= (sel_code == `PROTO_AUTO);
                  state <= st_start;
               end else if (cmd_write && cmd_op == op_restore_defaults) begin
                  current_code <= default_code;
               end
            end
            st_start: begin
               link_protocol <= current_code;
               link_start <= 1'b1;
               state <= st_wait;
            end
            st_wait: begin
               if (link_done) begin
                  if (link_ok) begin
                     state <= st_connected;
                  end else if (sel_auto || first_code == `PROTO_AUTO ||
                               try_auto) begin
                     state <= st_next;
                  end else begin
                     // [RL7] fixed selection stops at one attempt
                     state <= st_idle;
                  end
               end
            end
            st_next: begin
               // [RL9] ascend from 1, skipping the guess already tried
               if (!from_search) begin
                  from_search <= 1'b1;
                  current_code <= (first_code == `PROTO_FIRST) ? `PROTO_FIRST + 4'h1 : `PROTO_FIRST;
                  state <= st_start;
               end else if (current_code + 4'h1 == first_code && first_code != `PROTO_LAST) begin
                  current_code <= current_code + 4'h2;
                  state <= st_start;
               end else if (current_code < `PROTO_LAST && !(current_code + 4'h1 == first_code)) begin
                  current_code <= current_code + 4'h1;
                  state <= st_start;
               end else begin
                  // [RL20] every code failed
                  state <= st_idle;
               end
            end
            st_connected: begin
               if (cmd_write && cmd_op == op_close) begin
                  link_close <= 1'b1;
                  state <= st_idle;
               end else if (cmd_write && cmd_op == op_restore_defaults &&
                            default_code != current_code) begin
                  // [RL19] drop the session, fall back to the default
                  link_close <= 1'b1;
                  current_code <= default_code;
                  state <= st_idle;
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // [RL20] sticky no-connection result, a new attempt clears it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         no_connect <= 1'b0;
      end else if (state == st_wait && link_done && !link_ok && !sel_auto &&
                   first_code != `PROTO_AUTO) begin
         no_connect <= 1'b1;
      end else if (state == st_next && from_search &&
                   (current_code >= `PROTO_LAST ||
                    (current_code + 4'h1 == first_code && first_code == `PROTO_LAST))) begin
         no_connect <= 1'b1;
      end else if (state == st_start) begin
         no_connect <= 1'b0;
      end
   end

   // ----------------------------------------
   // protocol description
   // ----------------------------------------
   logic is_can;
   logic id29;
   logic [15:0] rate;

   // [RL3] codes 6 to 9 are CAN, odd ones 29-bit
   assign is_can = (current_code >= `PROTO_CAN_FIRST) && (current_code <= `PROTO_LAST);
   assign id29 = is_can && current_code[0];

   // [RL2] vehicle rate per code
   always_comb begin
      case (current_code)
         4'h1: rate = `RATE_PWM;
         4'h2: rate = `RATE_VPW;
         4'h3, 4'h4: rate = `RATE_SLOW_INIT;
         4'h5: rate = `RATE_SLOW_INIT;
         4'h6, 4'h7: rate = `RATE_CAN500;
         4'h8, 4'h9: rate = `RATE_CAN250;
         default: rate = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // framing of received vehicle messages
   // ----------------------------------------
   logic [3:0] pos;
   logic [3:0] data_count;
   logic [7:0] run_sum;
   logic checksum_err;
   logic length_err;
   logic [3:0] id_bytes;
   logic take_byte;

   assign id_bytes = id29 ? `CAN_ID29_BYTES : `CAN_ID11_BYTES;
   // [RL18] in-frame response bytes dropped outright
   assign take_byte = rx_valid && !rx_ifr;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos <= 4'h0;
         data_count <= 4'h0;
         run_sum <= 8'h00;
      end else if (take_byte) begin
         if (rx_last) begin
            pos <= 4'h0;
            data_count <= 4'h0;
            run_sum <= 8'h00;
         end else begin
            if (pos != 4'hf) begin
               pos <= pos + 4'h1;
            end
            if ((!is_can && pos >= `HEADER_BYTES) || (is_can && pos > id_bytes)) begin
               if (data_count != 4'hf) begin
                  data_count <= data_count + 4'h1;
               end
            end
            // [RL14] running total over the message
            run_sum <= run_sum + rx_data;
         end
      end
   end

   // set beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         checksum_err <= 1'b0;
         length_err <= 1'b0;
      end else begin
         // [RL14] compare the last byte with the total
         if (take_byte && rx_last && !is_can && run_sum != rx_data) begin
            checksum_err <= 1'b1;
         end else if (st_write && hwdata[`ST_CHECKSUM_ERR_BIT]) begin
            checksum_err <= 1'b0;
         end
         // [RL12] more than seven data bytes is malformed
         if (take_byte && data_count == `MAX_DATA_BYTES && !rx_last &&
             ((!is_can && pos >= `HEADER_BYTES) || (is_can && pos > id_bytes))) begin
            length_err <= 1'b1;
         end else if (st_write && hwdata[`ST_LENGTH_ERR_BIT]) begin
            length_err <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_valid <= 1'b0;
         host_data <= 8'h00;
         host_kind <= kind_data;
         host_frame_end <= 1'b0;
      end else begin
         host_valid <= 1'b0;
         host_frame_end <= 1'b0;
         if (take_byte) begin
            host_data <= rx_data;
            host_frame_end <= rx_last;
            if (!is_can) begin
               if (rx_last) begin
                  // [RL16] checksum only with headers shown
                  host_kind <= kind_checksum;
                  host_valid <= header_on;
               end else if (pos < `HEADER_BYTES) begin
                  // [RL13] priority, target_address, source_address in order
                  host_kind <= kind_header;
                  host_valid <= header_on;
               end else begin
                  host_kind <= kind_data;
                  host_valid <= 1'b1;
               end
            end else begin
               // [RL15] id bytes, pci, then data
               if (pos < id_bytes) begin
                  // [RL17] id bytes go out as hex by the host side
                  host_kind <= kind_header;
                  host_valid <= header_on;
               end else if (pos == id_bytes) begin
                  host_kind <= kind_pci;
                  host_valid <= header_on;
               end else begin
                  host_kind <= kind_data;
                  host_valid <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_valid && !hwrite) begin
         hrdata <= 32'h0000_0000;
         case (haddr)
            `OFS_STATUS: begin
               hrdata[`ST_CURRENT_LSB +: 4] <= current_code;
               hrdata[`ST_DEFAULT_LSB +: 4] <= default_code;
               hrdata[`ST_DEFAULT_AUTO_BIT] <= default_auto;
               hrdata[`ST_BUSY_BIT] <= (state == st_start) || (state == st_wait) ||
                                       (state == st_next);
               hrdata[`ST_CONNECTED_BIT] <= (state == st_connected);
               hrdata[`ST_NO_CONNECT_BIT] <= no_connect;
               hrdata[`ST_CHECKSUM_ERR_BIT] <= checksum_err;
               hrdata[`ST_LENGTH_ERR_BIT] <= length_err;
            end
            `OFS_CONFIG: begin
               hrdata[`CFG_HEADER_BIT] <= header_on;
               hrdata[`CFG_MEMORY_BIT] <= memory_on;
               hrdata[`CFG_BAUD_FAST_BIT] <= baud_fast;
            end
            `OFS_DESCRIBE: begin
               // [RL5] current protocol with auto marker
               hrdata[`DSC_CODE_LSB +: 4] <= current_code;
               hrdata[`DSC_AUTO_BIT] <= sel_auto;
               hrdata[`DSC_CAN_BIT] <= is_can;
               hrdata[`DSC_ID29_BIT] <= id29;
               hrdata[`DSC_RATE_LSB +: 16] <= rate;
            end
            default: begin
               hrdata <= 32'h0000_0000;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** tb/obd_vehicle_model.sv ***
// vehicle bus stand-in answering connection attempts
`timescale 1ns/1ns
`default_nettype none
module obd_vehicle_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic link_start,
   input wire logic [3:0] link_protocol,
   input wire logic [3:0] fit_code,
   input wire logic [3:0] delay,
   output logic link_done,
   output logic link_ok
);
   logic [3:0] cnt;
   logic hit;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 4'h0;
         hit <= 1'b0;
         link_done <= 1'b0;
      end else begin
         link_done <= cnt == 4'h1;
         if (link_start) begin
            cnt <= delay;
            hit <= link_protocol == fit_code;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
   // ok is meaningless off the done pulse
   assign link_ok = link_done ? hit : ~hit;
endmodule
`default_nettype wire

// *** tb/obd_select_assertions.sv ***
// port assertions for the protocol selection block
`timescale 1ns/1ns
`default_nettype none
module obd_select_checker #(
   parameter int unsigned DIV_WIDTH = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [DIV_WIDTH-1:0] host_baud_div,
   input wire logic [3:0] link_protocol,
   input wire logic link_start,
   input wire logic link_close,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_ifr,
   input wire logic host_valid,
   input wire logic [7:0] host_data,
   input wire logic host_frame_end
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_baud_legal: assert property (host_baud_div == 2604 || host_baud_div == 651)
      else $error("baud divisor illegal");
   a_proto_range: assert property (link_start |-> link_protocol inside {[1:9]})
      else $error("attempt on bad code");
   a_start_pulse: assert property (link_start |=> !link_start [*2])
      else $error("start not a pulse");
   a_close_alone: assert property (link_close |-> !link_start)
      else $error("close with start");
   a_ifr_dropped: assert property (rx_valid && rx_ifr |=> !host_valid)
      else $error("ifr byte forwarded");
   a_no_idle_out: assert property (!(rx_valid && !rx_ifr) |=> !host_valid && !host_frame_end)
      else $error("host byte from nothing");
   a_frame_end: assert property (rx_valid && !rx_ifr && rx_last |=> host_frame_end)
      else $error("frame end missing");
   a_data_copy: assert property (host_valid |-> host_data == $past(rx_data))
      else $error("host byte altered");
endmodule
bind obd_protocol_select obd_select_checker #(.DIV_WIDTH(DIV_WIDTH)) checker_inst (.*);
`default_nettype wire

// *** tb/obd_protocol_select_tb.sv ***
// self-checking bench for protocol selection and framing
`timescale 1ns/1ns
`default_nettype none
module obd_protocol_select_tb;
   import obd_select_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, memory_strap, baud_strap, hdr;
   logic link_start, link_close, link_done, link_ok, rx_valid, rx_last, rx_ifr, host_valid, host_frame_end;
   logic [7:0] haddr, rx_data, host_data;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rv, junk;
   logic [11:0] host_baud_div;
   logic [3:0] link_protocol, fit_code, delay;
   logic [15:0] rt [1:9] = '{16'd416, 16'd104, 16'd104, 16'd104, 16'd104, 16'd5000, 16'd5000, 16'd2500, 16'd2500};
   byte_kind_t host_kind;
   logic [31:0] q [$];
   int err_total, n_tests, cyc;
   event rd_ev;
   assign hready = hreadyout;
   obd_protocol_select obd_protocol_select_inst (.*);
   obd_vehicle_model obd_vehicle_model_inst (.*);
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [31:0] pop;
      return q.size() > 0 ? q.pop_front() : 32'hdead;
   endfunction
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(a, 1'b0, 32'h0, rv);
      q.push_back(e);
      rv = rv & m;
      -> rd_ev;
   endtask
   task automatic cmd(input logic [2:0] op, input logic a, input logic [3:0] c);
      bus(8'h00, 1'b1, {21'h0, op, 3'h0, a, c}, junk);
   endtask
   task automatic rst(input logic m);
      hresetn <= 1'b0;
      memory_strap <= m;
      baud_strap <= m;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask
   // bounded connection attempt
   task automatic conn(input logic [2:0] op, input logic [3:0] g, input logic [3:0] v, input logic srch);
      if (g != 4'h0) q.push_back(32'(g));
      for (int c = 1; c <= 9 && srch && g != v; c++) begin
         if (c != g) q.push_back(32'(c));
         if (c == v) break;
      end
      fit_code <= v;
      delay <= 4'(2 + $urandom % 8);
      cmd(op, 1'b1, g);
      junk = 32'h200;
      for (int i = 0; i < 300 && junk[9] !== 1'b0; i++) bus(8'h04, 1'b0, 32'h0, junk);
      chk(32'(q.size()), 32'h0, "left");
   endtask
   task automatic frame(input int n, input int idn, input logic bad);
      logic [7:0] b, s;
      byte_kind_t k;
      s = 8'h0;
      rx_valid <= 1'b1;
      rx_ifr <= 1'b1;
      rx_data <= 8'h5a;
      @(posedge hclk);
      rx_ifr <= 1'b0;
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         k = i < idn ? kind_header : kind_data;
         if (idn != 3 && i == idn) k = kind_pci;
         if (idn == 3 && i == n - 1) k = kind_checksum;
         if (k == kind_checksum) b = s ^ {7'h0, bad};
         if (hdr || k == kind_data) q.push_back(32'({k, b}));
         s = s + b;
         rx_data <= b;
         rx_last <= i == n - 1;
         @(posedge hclk);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(32'(q.size()), 32'h0, "left");
   endtask
   always @(rd_ev) chk(rv, pop(), "reg");
   always @(posedge hclk) begin
      cyc++;
      if (host_valid === 1'b1) chk(32'({host_kind, host_data}), pop(), "host");
      if (link_start === 1'b1) chk(32'(link_protocol), pop(), "proto");
      if (cyc == 40000) begin
         err_total++;
         end_of_test;
      end
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, rx_valid, rx_last, rx_ifr, rx_data} = '0;
      {memory_strap, baud_strap, fit_code, delay, hdr, err_total, n_tests, cyc} = '0;
      hsel = 1'b1;
      hsize = 3'h2;
      void'($urandom(32'h2d87));
      rst(1'b0);
      rd(8'h04, 32'h100, 32'h3fff);
      rd(8'h10, 32'h0, 32'hffffffff);
      chk(32'(host_baud_div), 32'd2604, "div");
      for (int c = 1; c <= 9; c++) begin
         cmd(3'd1, c[0], 4'(c));
         cmd(3'd3, 1'b0, 4'h0);
         rd(8'h0c, {8'h0, rt[c], 1'b0, c == 7 || c == 9, c >= 6, c[0], 4'(c)}, 32'hffffff);
      end
      cmd(3'd1, 1'b0, 4'hc);
      cmd(3'd3, 1'b0, 4'h0);
      rd(8'h0c, {8'h0, 16'd2500, 8'h79}, 32'hffffff);
      cmd(3'd1, 1'b0, 4'h2);
      cmd(3'd3, 1'b0, 4'h0);
      conn(3'd4, 4'h2, 4'h5, 1'b0);
      rd(8'h04, 32'h822, 32'hfff);
      conn(3'd2, 4'h3, 4'h5, 1'b1);
      bus(8'h08, 1'b1, 32'h1, junk);
      hdr = 1'b1;
      frame(11, 3, 1'b0);
      bus(8'h08, 1'b1, 32'h0, junk);
      hdr = 1'b0;
      frame(12, 3, 1'b1);
      rd(8'h04, 32'h3000, 32'h3000);
      bus(8'h04, 1'b1, 32'h3000, junk);
      rd(8'h04, 32'h0, 32'h3000);
      cmd(3'd1, 1'b1, 4'h3);
      cmd(3'd3, 1'b0, 4'h0);
      conn(3'd4, 4'h3, 4'h6, 1'b1);
      rd(8'h04, 32'h536, 32'h7ff);
      bus(8'h08, 1'b1, 32'h1, junk);
      hdr = 1'b1;
      frame(7, 2, 1'b0);
      bus(8'h08, 1'b1, 32'h0, junk);
      hdr = 1'b0;
      frame(7, 2, 1'b0);
      cmd(3'd5, 1'b0, 4'h0);
      repeat (4) @(posedge hclk);
      rd(8'h04, 32'h0, 32'h600);
      rst(1'b1);
      chk(32'(host_baud_div), 32'd651, "div");
      rd(8'h08, 32'h6, 32'h7);
      conn(3'd4, 4'h0, 4'h8, 1'b1);
      rd(8'h04, 32'h188, 32'h1ff);
      cmd(3'd5, 1'b0, 4'h0);
      repeat (4) @(posedge hclk);
      cmd(3'd3, 1'b0, 4'h0);
      conn(3'd4, 4'h8, 4'h8, 1'b1);
      end_of_test;
   end
endmodule
`default_nettype wire
